//--- verilog/pilu_unit.sv
// Purpose: Interrupt latches, enables and acceptance for the core
// Assumes: Source inputs are one-cycle request pulses
// Notes: Core must drop trap_req_i before the sequence ends
`default_nettype none
`include "pilu_defs.svh"
module pilu_unit
	import pilu_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire pilu_src_t   src_i,
	input  wire logic        trap_req_i,
	input  wire logic        ext0_pin_enable_i,
	input  wire logic        level15_source_select_i,
	input  wire logic        level16_source_select_i,
	input  wire logic        boundary_i,
	input  wire logic        ret_i,
	input  wire logic        ret_imf_i,
	input  wire logic [15:0] sfr_addr_i,
	input  wire logic        sfr_wr_i,
	input  wire logic        sfr_rd_i,
	input  wire logic [7:0]  sfr_wdata_i,
	output logic [7:0]       sfr_rdata_o,
	output logic             int_req_o,
	output logic             accept_o,
	output logic [15:0]      vector_o,
	output logic             stacked_imf_o,
	output logic             busy_o,
	output logic             done_o
);

	pilu_state_t st_ff;
	pilu_state_t nxt_st;
	pilu_state_t rst_st;

	logic [15:0] set_v;
	logic [15:0] clr_v;
	logic [15:0] qual_v;
	logic        found;
	logic [3:0]  win_idx;
	logic        accept_now;
	logic        wr_il_lo;
	logic        wr_il_hi;

	// Shared levels: unselected source never reaches its latch
	assign set_v = {
		level16_source_select_i ? src_i.adc_done_irq : src_i.ext_irq5,
		level15_source_select_i ? src_i.uart_tx_irq : src_i.ext_irq4,
		src_i.uart_rx_irq,
		src_i.serial_io_irq,
		src_i.ext_irq3,
		src_i.timer3_irq,
		src_i.timer4_irq,
		src_i.ext_irq2,
		src_i.timer1_irq,
		src_i.time_base_irq,
		src_i.ext_irq1,
		src_i.ext_irq0,
		src_i.watchdog_irq,
		src_i.address_trap_irq,
		2'b00
	};

	assign wr_il_lo = sfr_wr_i && (sfr_addr_i == `PILU_ADDR_IL_LO);
	assign wr_il_hi = sfr_wr_i && (sfr_addr_i == `PILU_ADDR_IL_HI);

	// Zero bits clear, one bits leave the latch alone
	assign clr_v = {wr_il_hi ? ~sfr_wdata_i : 8'h00,
		wr_il_lo ? ~sfr_wdata_i : 8'h00} & `PILU_LATCH_USED;

	always_comb begin
		qual_v = 16'h0000;
		qual_v[`PILU_BIT_TRAP] = trap_req_i;
		for (int b = 2; b < 16; b++) begin
			if (b < `PILU_BIT_FIRST_MSK) begin
				qual_v[b] = st_ff.latch[b];
			end else begin
				qual_v[b] = st_ff.latch[b] & st_ff.master_enable_flag & st_ff.ef[b];
			end
		end
		qual_v[`PILU_BIT_EXT0] = qual_v[`PILU_BIT_EXT0] & ext0_pin_enable_i;
	end

	pilu_resolver u_resolver (
		.req_i   (qual_v),
		.found_o (found),
		.idx_o   (win_idx)
	);

	// One acceptance at a time, only at an instruction boundary
	assign accept_now = boundary_i && found && (st_ff.phase == PILU_IDLE);

	always_comb begin
		rst_st             = '0;
		rst_st.latch       = `PILU_LATCH_RESET;
		rst_st.ef          = `PILU_EF_RESET;
		rst_st.phase       = PILU_IDLE;
		rst_st.vector      = `PILU_VEC_TOP;
	end

	always_comb begin
		nxt_st        = st_ff;
		nxt_st.accept = 1'b0;
		nxt_st.done   = 1'b0;

		// Set wins over both kinds of clear in the same cycle
		nxt_st.latch = (st_ff.latch & ~clr_v) | set_v;
		if (accept_now && (win_idx != `PILU_BIT_TRAP)) begin
			nxt_st.latch[win_idx] = set_v[win_idx];
		end
		nxt_st.latch = nxt_st.latch & `PILU_LATCH_USED;

		if (sfr_wr_i && (sfr_addr_i == `PILU_ADDR_EIR_LO)) begin
			nxt_st.master_enable_flag     = sfr_wdata_i[0];
			nxt_st.ef[7:0] = sfr_wdata_i & 8'hf0;
		end
		if (sfr_wr_i && (sfr_addr_i == `PILU_ADDR_EIR_HI)) begin
			nxt_st.ef[15:8] = sfr_wdata_i;
		end
		if (ret_i) begin
			nxt_st.master_enable_flag = ret_imf_i;
		end

		// Read data is captured one cycle after the strobe
		if (sfr_rd_i) begin
			unique case (sfr_addr_i)
				`PILU_ADDR_IL_LO:  nxt_st.rdata = st_ff.latch[7:0];
				`PILU_ADDR_IL_HI:  nxt_st.rdata = st_ff.latch[15:8];
				`PILU_ADDR_EIR_LO: nxt_st.rdata = {st_ff.ef[7:4], 3'b000, st_ff.master_enable_flag};
				`PILU_ADDR_EIR_HI: nxt_st.rdata = st_ff.ef[15:8];
				default:           nxt_st.rdata = 8'h00;
			endcase
		end

		unique case (st_ff.phase)
			PILU_IDLE: begin
				if (accept_now) begin
					nxt_st.phase       = PILU_SEQ;
					nxt_st.cnt         = 6'h00;
					nxt_st.accept      = 1'b1;
					nxt_st.vec_idx     = win_idx;
					nxt_st.vector      = pilu_vec_of(win_idx);
					nxt_st.stacked_imf = st_ff.master_enable_flag;
					// Hardware clear beats a write in the same cycle
					nxt_st.master_enable_flag         = 1'b0;
				end
			end
			PILU_SEQ: begin
				if (st_ff.cnt == 6'(`PILU_SEQ_CLKS - 1)) begin
					nxt_st.phase = PILU_IDLE;
					nxt_st.done  = 1'b1;
				end else begin
					nxt_st.cnt = st_ff.cnt + 6'h01;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= rst_st;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sfr_rdata_o   = st_ff.rdata;
	assign int_req_o     = found && (st_ff.phase == PILU_IDLE);
	assign accept_o      = st_ff.accept;
	assign vector_o      = st_ff.vector;
	assign stacked_imf_o = st_ff.stacked_imf;
	assign busy_o        = (st_ff.phase == PILU_SEQ);
	assign done_o        = st_ff.done;

	// Helper for the priority check: bits below the winner
	logic [15:0] below_win;
	assign below_win = (16'h0001 << win_idx) - 16'h0001;

	a_latch_set: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> ((st_ff.latch & $past(set_v)) == $past(set_v)))
		else $error("request pulse did not set its latch");

	a_accept_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(accept_now && win_idx != `PILU_BIT_TRAP && !set_v[win_idx])
		|=> !st_ff.latch[$past(win_idx)])
		else $error("accepted latch not cleared");

	a_imf_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		accept_now |=> (!st_ff.master_enable_flag && stacked_imf_o == $past(st_ff.master_enable_flag)))
		else $error("master flag not stacked and cleared");

	a_write_no_set: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_il_lo && set_v[7:0] == 8'h00)
		|=> ((st_ff.latch[7:0] & ~$past(st_ff.latch[7:0])) == 8'h00))
		else $error("software write set a latch");

	a_reset_zero: assert property (@(posedge clk_i)
		rst_i |=> (st_ff.latch == 16'h0000 && !st_ff.master_enable_flag && st_ff.ef == 16'h0000))
		else $error("reset left a latch or flag set");

	a_seq_length: assert property (@(posedge clk_i) disable iff (rst_i)
		accept_now |=> (busy_o && !done_o) ##31 busy_o ##1 (done_o && !busy_o))
		else $error("acceptance sequence length wrong");

	a_mask_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		(accept_now && win_idx >= `PILU_BIT_FIRST_MSK)
		|-> (st_ff.master_enable_flag && st_ff.ef[win_idx] && st_ff.latch[win_idx]))
		else $error("maskable source accepted while masked");

	a_prio_order: assert property (@(posedge clk_i) disable iff (rst_i)
		accept_now |-> ((qual_v & below_win) == 16'h0000))
		else $error("lower priority accepted first");

	a_vector_out: assert property (@(posedge clk_i) disable iff (rst_i)
		accept_now |=> (accept_o && vector_o == pilu_vec_of($past(win_idx))))
		else $error("wrong vector presented");

	a_read_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		(sfr_rd_i && sfr_addr_i == `PILU_ADDR_IL_LO)
		|=> (sfr_rdata_o == $past(st_ff.latch[7:0]) && sfr_rdata_o[1:0] == 2'b00))
		else $error("latch read returned wrong value");

	a_unsel_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		(level15_source_select_i && !src_i.uart_tx_irq && !st_ff.latch[14]
			&& !wr_il_hi) |=> (st_ff.latch[14] == 1'b0))
		else $error("unselected shared source was latched");

endmodule // pilu_unit
`default_nettype wire

//--- verilog/pilu_defs.svh
// Purpose: Constants for the prioritized interrupt latch unit
// Assumes: One core clock, synchronous active-high reset
// Notes: Offsets are SFR byte addresses
`ifndef PILU_DEFS_SVH
`define PILU_DEFS_SVH

`define PILU_ADDR_EIR_LO   16'h003a
`define PILU_ADDR_EIR_HI   16'h003b
`define PILU_ADDR_IL_LO    16'h003c
`define PILU_ADDR_IL_HI    16'h003d

`define PILU_LATCH_RESET   16'h0000
`define PILU_EF_RESET      16'h0000
`define PILU_LATCH_USED    16'hfffc
`define PILU_EF_USED       16'hfff0

`define PILU_BIT_TRAP      4'h1
`define PILU_BIT_FIRST_MSK 4'h4
`define PILU_BIT_EXT0      4'h4

`define PILU_VEC_TOP       16'hfffe

`define PILU_ACCEPT_MC     8
`define PILU_CLK_PER_MC    4
`define PILU_SEQ_CLKS      (`PILU_ACCEPT_MC * `PILU_CLK_PER_MC)

`endif

//--- verilog/pilu_pkg.sv
// Purpose: Types shared by the interrupt latch unit
// Assumes: pilu_defs.svh constants
// Notes: Vector follows bit index, two bytes per level
`default_nettype none
`include "pilu_defs.svh"
package pilu_pkg;

	typedef enum logic {
		PILU_IDLE,
		PILU_SEQ
	} pilu_phase_t;

	typedef struct packed {
		logic adc_done_irq;
		logic ext_irq5;
		logic uart_tx_irq;
		logic ext_irq4;
		logic uart_rx_irq;
		logic serial_io_irq;
		logic ext_irq3;
		logic timer3_irq;
		logic timer4_irq;
		logic ext_irq2;
		logic timer1_irq;
		logic time_base_irq;
		logic ext_irq1;
		logic ext_irq0;
		logic watchdog_irq;
		logic address_trap_irq;
	} pilu_src_t;

	typedef struct packed {
		logic [15:0] latch;
		logic [15:0] ef;
		logic        master_enable_flag;
		pilu_phase_t phase;
		logic [5:0]  cnt;
		logic [15:0] vector;
		logic [3:0]  vec_idx;
		logic [7:0]  rdata;
		logic        stacked_imf;
		logic        accept;
		logic        done;
	} pilu_state_t;

	// Bit index b maps to priority b+1 and vector FFFE - 2b
	function automatic logic [15:0] pilu_vec_of(input logic [3:0] idx);
		pilu_vec_of = `PILU_VEC_TOP - {11'h000, idx, 1'b0};
	endfunction

endpackage
`default_nettype wire

//--- verilog/pilu_resolver.sv
// Purpose: Fixed priority pick among qualified requests
// Assumes: Bit 0 never requests
// Notes: Lowest index is highest priority
`default_nettype none
module pilu_resolver
	import pilu_pkg::*;
(
	input  wire logic [15:0] req_i,
	output logic             found_o,
	output logic [3:0]       idx_o
);

	always_comb begin
		found_o = 1'b0;
		idx_o   = 4'h0;
		// Descending scan so the lowest set bit is left standing
		for (int i = 15; i >= 1; i--) begin
			if (req_i[i]) begin
				found_o = 1'b1;
				idx_o   = 4'(i);
			end
		end
	end

endmodule // pilu_resolver
`default_nettype wire

//--- tb/pilu_core_model.sv
// Purpose: Core-side model giving boundaries and trap requests
// Assumes: Bench asks for boundaries through run_i
// Notes: Trap level held until the unit's next accept pulse, whichever source won
`default_nettype none
module pilu_core_model (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic run_i,
	input  wire logic trap_i,
	input  wire logic accept_i,
	input  wire logic busy_i,
	output logic      boundary_o,
	output logic      trap_req_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Core stalls while the unit sequences
	assign boundary_o = run_i & ~busy_i;
	always_ff @(posedge clk_i) begin
		if (rst_i || accept_i)
			trap_req_o <= 1'b0;
		else if (trap_i)
			trap_req_o <= 1'b1;
	end
endmodule // pilu_core_model
`default_nettype wire

//--- tb/prioritized_interrupt_latch_unit_tb.sv
// Purpose: Self-checking bench for the interrupt latch unit
// Assumes: Inputs change on the falling edge
// Notes: Rows cover each latched source's vector, hand tests the rest
`default_nettype none
module prioritized_interrupt_latch_unit_tb
	import pilu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [15:0] src;
		logic [15:0] ef;
		logic [1:0]  sel;
		logic [15:0] vec;
	} pilu_row_t;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        run = 1'b0;
	logic        trap = 1'b0;
	logic        ext0_en = 1'b1;
	logic        ret = 1'b0;
	logic        ret_imf = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [1:0]  sel = 2'h0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	pilu_src_t   src = '0;
	logic [7:0]  rdata, lo, hi;
	logic [15:0] vector, idx, lat;
	logic        int_req, accept, stacked, busy, done, boundary, trap_req;
	int          bad_count = 0;
	int          total_checks = 0;
	pilu_row_t   rows [18];

	always #25 clk_i = ~clk_i;

	pilu_core_model u_pilu_core_model (
		.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .trap_i(trap), .accept_i(accept),
		.busy_i(busy), .boundary_o(boundary), .trap_req_o(trap_req)
	);
	pilu_unit u_pilu_unit (
		.clk_i(clk_i), .rst_i(rst_i), .src_i(src), .trap_req_i(trap_req),
		.ext0_pin_enable_i(ext0_en), .level15_source_select_i(sel[0]),
		.level16_source_select_i(sel[1]), .boundary_i(boundary), .ret_i(ret),
		.ret_imf_i(ret_imf), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
		.sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .int_req_o(int_req), .accept_o(accept),
		.vector_o(vector), .stacked_imf_o(stacked), .busy_o(busy), .done_o(done)
	);

	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s exp %h seen %h", n, exp, seen);
		end
	endtask
	// Spare cycle after each strobe keeps one assignment per time step
	task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_i);
		wr = 1'b0;
		@(negedge clk_i);
	endtask
	task automatic rc(input string n, input logic [15:0] a, input logic [7:0] e);
		addr = a;
		rd = 1'b1;
		@(negedge clk_i);
		rd = 1'b0;
		lo = rdata;
		chk(n, {8'h00, lo}, {8'h00, e});
		@(negedge clk_i);
	endtask
	task automatic pulse(input logic [15:0] v);
		src = v;
		@(negedge clk_i);
		src = '0;
	endtask
	task automatic take(input string n, input logic [15:0] v);
		int k;
		run = 1'b1;
		for (k = 0; k < 40 && accept !== 1'b1; k++)
			@(negedge clk_i);
		chk("accept pulse", {15'h0, accept}, 16'h0001);
		chk(n, vector, v);
		for (k = 0; k < 40 && done !== 1'b1; k++)
			@(negedge clk_i);
		chk("sequence length", 16'(k), 16'h0020);
		run = 1'b0;
		// Idle cycle so a following take never re-drives run in this step
		@(negedge clk_i);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		test_done();
	end

	initial begin
		for (int k = 0; k < 10; k++)
			rows[k] = '{16'h0004 << k, (16'h0010 << k) | 16'h0001, 2'h0, 16'hfff6 - 16'(2 * k)};
		rows[10] = '{16'h1000, 16'h4001, 2'h0, 16'hffe2};
		rows[11] = '{16'h2000, 16'h4001, 2'h1, 16'hffe2};
		rows[12] = '{16'h4000, 16'h8001, 2'h0, 16'hffe0};
		rows[13] = '{16'h8000, 16'h8001, 2'h2, 16'hffe0};
		rows[14] = '{16'h0001, 16'h0000, 2'h0, 16'hfffa};
		rows[15] = '{16'h0002, 16'h0000, 2'h0, 16'hfff8};
		rows[16] = '{16'h0018, 16'h0061, 2'h0, 16'hfff4};
		rows[17] = '{16'h0018, 16'h0041, 2'h0, 16'hfff2};
		repeat (20) @(negedge clk_i);
		rst_i = 1'b0;
		rc("reset latch", 16'h003c, 8'h00);
		chk("reset vector", vector, 16'hfffe);
		foreach (rows[r]) begin
			sel = rows[r].sel;
			wr_b(16'h003a, 8'h00);
			wr_b(16'h003b, rows[r].ef[15:8]);
			wr_b(16'h003a, rows[r].ef[7:0]);
			pulse(rows[r].src);
			take("vector", rows[r].vec);
			chk("stacked", {15'h0, stacked}, {15'h0, rows[r].ef[0]});
			rc("master off", 16'h003a, {rows[r].ef[7:4], 4'h0});
			rc("latch", 16'h003d, 8'h00);
			hi = lo;
			addr = 16'h003c;
			rd = 1'b1;
			@(negedge clk_i);
			rd = 1'b0;
			lat = {hi, rdata};
			idx = (16'hfffe - rows[r].vec) >> 1;
			chk("winner latch", {15'h0, lat[idx[3:0]]}, 16'h0000);
			@(negedge clk_i);
			wr_b(16'h003c, 8'h0c);
			$display("row %0d finished", r);
		end
		wr_b(16'h003a, 8'h00);
		pulse(16'h0018);
		rc("pending", 16'h003c, 8'h60);
		wr_b(16'h003c, 8'hff);
		rc("ones write", 16'h003c, 8'h60);
		wr_b(16'h003c, 8'hdf);
		rc("zero write", 16'h003c, 8'h40);
		wr_b(16'h003b, 8'hff);
		wr_b(16'h003a, 8'hf0);
		chk("masked", {15'h0, int_req}, 16'h0000);
		wr_b(16'h003a, 8'hf1);
		chk("unmasked", {15'h0, int_req}, 16'h0001);
		wr_b(16'h003a, 8'hf0);
		wr_b(16'h003c, 8'h0c);
		$display("latch access test finished");
		ext0_en = 1'b0;
		pulse(16'h0004);
		wr_b(16'h003a, 8'hf1);
		chk("pin off", {15'h0, int_req}, 16'h0000);
		ext0_en = 1'b1;
		@(negedge clk_i);
		take("pin on", 16'hfff6);
		sel = 2'h1;
		pulse(16'h1000);
		rc("unselected", 16'h003d, 8'h00);
		sel = 2'h0;
		trap = 1'b1;
		pulse(16'h0001);
		trap = 1'b0;
		take("trap first", 16'hfffc);
		take("address trap", 16'hfffa);
		ret_imf = 1'b1;
		ret = 1'b1;
		@(negedge clk_i);
		ret = 1'b0;
		rc("return", 16'h003a, 8'hf1);
		rc("unmapped", 16'h0050, 8'h00);
		$display("gating test finished");
		pulse(16'h0008);
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		rc("rerun latch", 16'h003c, 8'h00);
		rc("rerun master", 16'h003a, 8'h00);
		$display("reset test finished");
		test_done();
	end
endmodule // prioritized_interrupt_latch_unit_tb
`default_nettype wire
